// ==== lift_shaft_access_safety_logic.v ====
// Purpose: Latching shaft access, stopping and traction safety logic
// Assumes: Pins are asynchronous; NV store answers on pclk
// Notes: Relay outputs high means relay energised (circuit closed)
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "lift_access_regs.vh"
module lift_shaft_access_safety_logic #(
  parameter integer CYCLES_PER_MS = `CLK_HZ / 1000,
  parameter integer HOLD_MIN_MS = `HOLD_MIN_MS,
  parameter integer HOLD_MAX_MS = `HOLD_MAX_MS
) (
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  // Pins from the shaft
  input wire roof_door_closed,
  input wire pit_door_closed,
  input wire roof_reset_btn,
  input wire pit_reset_btn,
  input wire roof_insp_on,
  input wire pit_insp_on,
  input wire roof_guard_active,
  input wire pit_guard_active,
  input wire safety_circuit_closed,
  input wire roof_end_switch,
  input wire pit_end_switch,
  input wire car_moving,
  input wire car_decelerating,
  input wire boot_locked_cfg,
  input wire site_key,
  // Non-volatile store
  input wire nv_rd_valid,
  input wire [3:0] nv_rd_data,
  output reg nv_wr_en,
  output reg [3:0] nv_wr_data,
  // Outputs
  output reg safety_circuit_relay,
  output reg safety_brake_relay,
  output reg normal_op_allowed,
  output reg inspection_allowed,
  output reg pit_insp_unlock
);

  localparam integer PIN_W = 15;
  localparam ST_LOAD = 1'b0;
  localparam ST_RUN = 1'b1;
  localparam integer STANDSTILL_MS = `STANDSTILL_MS;
  localparam integer DECEL_WAIT_MS = `DECEL_WAIT_MS;
  // ----------------------------------------------------------------
  // Three-stage pin synchroniser, change taken when stages 2 and 3 agree
  // ----------------------------------------------------------------
  wire [PIN_W-1:0] pin_raw;
  reg [PIN_W-1:0] sync1;
  reg [PIN_W-1:0] sync2;
  reg [PIN_W-1:0] sync3;
  reg [PIN_W-1:0] pin;
  assign pin_raw = {site_key, boot_locked_cfg, car_decelerating, car_moving,
    pit_end_switch, roof_end_switch, safety_circuit_closed, pit_guard_active,
    roof_guard_active, pit_insp_on, roof_insp_on, pit_reset_btn,
    roof_reset_btn, pit_door_closed, roof_door_closed};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= {PIN_W{1'b0}};
      sync2 <= {PIN_W{1'b0}};
      sync3 <= {PIN_W{1'b0}};
      pin <= {PIN_W{1'b0}};
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      pin <= (sync3 & ~(sync2 ^ sync3)) | (pin & (sync2 ^ sync3));
    end
  end
  wire roof_closed = pin[0];
  wire pit_closed = pin[1];
  wire roof_btn = pin[2];
  wire pit_btn = pin[3];
  wire roof_insp = pin[4];
  wire pit_insp = pin[5];
  wire roof_guard = pin[6];
  wire pit_guard = pin[7];
  wire circuit_closed = pin[8];
  wire end_switch_any = pin[9] | pin[10];
  wire moving = pin[11];
  wire decelerating = pin[12];
  wire boot_locked = pin[13];
  wire key_on = pin[14];
  // ----------------------------------------------------------------
  // One millisecond enable
  // ----------------------------------------------------------------
  reg [19:0] div_cnt;
  reg ms_tick;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 20'h00000;
      ms_tick <= 1'b0;
    end else if (div_cnt >= CYCLES_PER_MS[19:0] - 20'h00001) begin
      div_cnt <= 20'h00000;
      ms_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 20'h00001;
      ms_tick <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Reset press qualification
  // ----------------------------------------------------------------
  wire roof_press_ok;
  wire pit_press_ok;
  reset_press_qualifier #(.MIN_MS(HOLD_MIN_MS), .MAX_MS(HOLD_MAX_MS)) u_roof_press (
    .pclk(pclk), .presetn(presetn), .ms_tick(ms_tick), .btn(roof_btn),
    .valid(roof_press_ok));
  reset_press_qualifier #(.MIN_MS(HOLD_MIN_MS), .MAX_MS(HOLD_MAX_MS)) u_pit_press (
    .pclk(pclk), .presetn(presetn), .ms_tick(ms_tick), .btn(pit_btn),
    .valid(pit_press_ok));
  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  reg [9:0] brake_ms;
  reg [1:0] wired;
  reg clear_stop_req;
  reg clear_traction_req;
  reg state;
  reg roof_latch;
  reg pit_latch;
  reg stop_latch;
  reg traction_latch;
  wire setup = psel && !penable;
  wire wr_done = psel && penable && pwrite;
  wire mapped = (paddr == `REG_CLEAR_OFS) || (paddr == `REG_STATUS_OFS) ||
    (paddr == `REG_BRAKE_MS_OFS) || (paddr == `REG_WIRED_OFS);
  assign pready = 1'b1;
  // Read data and error captured in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= !mapped;
      case (paddr)
        `REG_STATUS_OFS: prdata <= {20'h00000, key_on, circuit_closed,
          pit_insp_unlock, state, safety_brake_relay, safety_circuit_relay,
          normal_op_allowed, inspection_allowed, traction_latch, stop_latch,
          pit_latch, roof_latch};
        `REG_BRAKE_MS_OFS: prdata <= {22'h000000, brake_ms};
        `REG_WIRED_OFS: prdata <= {30'h00000000, wired};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
  // Writable settings and clear strobes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brake_ms <= `BRAKE_MS_RESET;
      wired <= `WIRED_RESET;
      clear_stop_req <= 1'b0;
      clear_traction_req <= 1'b0;
    end else begin
      clear_stop_req <= wr_done && (paddr == `REG_CLEAR_OFS) &&
        pwdata[`CLEAR_STOP_BIT];
      clear_traction_req <= wr_done && (paddr == `REG_CLEAR_OFS) &&
        pwdata[`CLEAR_TRACTION_BIT];
      if (wr_done && (paddr == `REG_BRAKE_MS_OFS)) begin
        brake_ms <= pwdata[9:0];
      end
      if (wr_done && (paddr == `REG_WIRED_OFS)) begin
        wired <= pwdata[1:0];
      end
    end
  end
  // ----------------------------------------------------------------
  // Access monitoring latches
  // ----------------------------------------------------------------
  wire roof_open_evt = wired[0] && !roof_closed;
  wire pit_open_evt = wired[1] && !pit_closed;
  // Reset interlocks per access point
  wire roof_clear_ok = roof_press_ok && !roof_insp && !roof_guard &&
    circuit_closed;
  wire pit_clear_ok = pit_press_ok && !pit_insp && !pit_guard &&
    circuit_closed;
  // ----------------------------------------------------------------
  // Loss of traction monitor
  // ----------------------------------------------------------------
  reg circuit_q;
  reg was_moving;
  reg [9:0] open_ms;
  reg [6:0] still_ms;
  reg traction_evt;
  // Timers started when the safety circuit opens
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      circuit_q <= 1'b1;
      was_moving <= 1'b0;
      open_ms <= 10'h000;
      still_ms <= 7'h00;
      traction_evt <= 1'b0;
    end else begin
      circuit_q <= circuit_closed;
      traction_evt <= 1'b0;
      if (circuit_closed || state != ST_RUN) begin
        open_ms <= 10'h000;
        still_ms <= 7'h00;
      end else begin
        if (circuit_q) begin
          was_moving <= moving;
        end
        if (ms_tick && open_ms != 10'h3FF) begin
          open_ms <= open_ms + 10'h001;
        end
        if (!moving) begin
          still_ms <= 7'h00;
        end else if (ms_tick && still_ms != 7'h7F) begin
          still_ms <= still_ms + 7'h01;
        end
        // Brake monitoring: still moving after the brake time
        if (was_moving && moving && open_ms >= brake_ms) begin
          traction_evt <= 1'b1;
        end
        // Standstill monitoring: movement from the stop position
        if (!was_moving && still_ms >= STANDSTILL_MS[6:0]) begin
          traction_evt <= 1'b1;
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // Pre-triggered stopping, always armed with the end switches
  // ----------------------------------------------------------------
  reg [7:0] decel_ms;
  reg stop_evt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      decel_ms <= 8'h00;
      stop_evt <= 1'b0;
    end else begin
      stop_evt <= 1'b0;
      // No enable exists: end switch, moving car, no deceleration and run state gate it
      if (!end_switch_any || !moving || decelerating || state != ST_RUN) begin
        decel_ms <= 8'h00;
      end else if (decel_ms >= DECEL_WAIT_MS[7:0]) begin
        stop_evt <= 1'b1;
      end else if (ms_tick) begin
        decel_ms <= decel_ms + 8'h01;
      end
    end
  end
  // ----------------------------------------------------------------
  // Latches, restore sequence and store writes
  // ----------------------------------------------------------------
  reg [3:0] next_latches;
  always @* begin
    next_latches = {traction_latch, stop_latch, pit_latch, roof_latch};
    // Events win over clears in the same cycle
    if (pit_clear_ok) begin
      next_latches[`NV_PIT_BIT] = 1'b0;
    end
    if (roof_clear_ok) begin
      next_latches[`NV_ROOF_BIT] = 1'b0;
    end
    if (clear_stop_req && key_on) begin
      next_latches[`NV_STOP_BIT] = 1'b0;
    end
    if (clear_traction_req && key_on) begin
      next_latches[`NV_TRACTION_BIT] = 1'b0;
    end
    if (roof_open_evt) begin
      next_latches[`NV_ROOF_BIT] = 1'b1;
    end
    if (pit_open_evt) begin
      next_latches[`NV_PIT_BIT] = 1'b1;
    end
    if (stop_evt) begin
      next_latches[`NV_STOP_BIT] = 1'b1;
    end
    if (traction_evt) begin
      next_latches[`NV_TRACTION_BIT] = 1'b1;
    end
  end
  // Restore from the store first, then run
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_LOAD;
      roof_latch <= 1'b1;
      pit_latch <= 1'b1;
      stop_latch <= 1'b1;
      traction_latch <= 1'b1;
      nv_wr_en <= 1'b0;
      nv_wr_data <= 4'hF;
      pit_insp_unlock <= 1'b0;
    end else begin
      nv_wr_en <= 1'b0;
      pit_insp_unlock <= 1'b0;
      case (state)
        ST_LOAD: begin
          if (nv_rd_valid) begin
            state <= ST_RUN;
            // Stored state, or locked boot when configured
            roof_latch <= nv_rd_data[`NV_ROOF_BIT] | (boot_locked & wired[0]);
            pit_latch <= nv_rd_data[`NV_PIT_BIT] | (boot_locked & wired[1]);
            stop_latch <= nv_rd_data[`NV_STOP_BIT];
            traction_latch <= nv_rd_data[`NV_TRACTION_BIT];
            nv_wr_data <= nv_rd_data;
          end
        end
        ST_RUN: begin
          roof_latch <= next_latches[`NV_ROOF_BIT];
          pit_latch <= next_latches[`NV_PIT_BIT];
          stop_latch <= next_latches[`NV_STOP_BIT];
          traction_latch <= next_latches[`NV_TRACTION_BIT];
          // Pit reset also frees a locked pit inspection
          pit_insp_unlock <= pit_clear_ok && !pit_open_evt;
          // Every latch change is written through
          if (next_latches != {traction_latch, stop_latch, pit_latch,
              roof_latch}) begin
            nv_wr_en <= 1'b1;
            nv_wr_data <= next_latches;
          end
        end
        default: begin
          state <= ST_LOAD;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Relay and mode outputs
  // ----------------------------------------------------------------
  wire access_latched = roof_latch | pit_latch;
  wire insp_any = roof_insp | pit_insp;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      safety_circuit_relay <= 1'b0;
      safety_brake_relay <= 1'b0;
      normal_op_allowed <= 1'b0;
      inspection_allowed <= 1'b0;
    end else if (state != ST_RUN) begin
      safety_circuit_relay <= 1'b0;
      safety_brake_relay <= 1'b0;
      normal_op_allowed <= 1'b0;
      inspection_allowed <= 1'b0;
    end else begin
      // Only with both access points reset
      normal_op_allowed <= !access_latched && !insp_any;
      // Inspection only with doors closed and locked again
      inspection_allowed <= roof_closed && pit_closed;
      // Brake trip or traction trip keeps the circuit open
      safety_circuit_relay <= !stop_latch && !traction_latch &&
        !end_switch_any && !(access_latched && !insp_any);
      safety_brake_relay <= !stop_latch && !traction_latch;
    end
  end
endmodule
`default_nettype wire

// ==== lift_access_regs.vh ====
// Purpose: Constants for the shaft access safety logic
// Assumes: 32-bit APB, one register per aligned word
// Notes: All times in their own unit; cycle counts derived in code
//
// Notes on behaviour
// - Door opening sets its own access latch
// - Latched access blocks normal, permits inspection
// - Access latches kept in non-volatile store
// - Safe input forces locked access at boot
// - Roof and pit latches clear independently
// - Pit reset also unlocks pit inspection
// - Reset press valid only held 3 to 6 s
// - Reset needs that point's inspection off
// - Reset needs that point's safeguard inactive
// - Reset needs safety circuit closed
// - Normal operation only with both latches clear
// - Stopping function always on, with end switches
// - End switch opens circuit, then brake if no decel
// - Brake trip holds circuit relay open until cleared on site
// - Stopping trip stored, cleared only on site
// - Movement with open circuit opens both relays
// - Traction trip latches, on-site clear only
// - Reaction 69 ms standstill, 609-919 ms brake
`ifndef LIFT_ACCESS_REGS_VH
`define LIFT_ACCESS_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define REG_CLEAR_OFS 12'h000
`define REG_STATUS_OFS 12'h004
`define REG_BRAKE_MS_OFS 12'h008
`define REG_WIRED_OFS 12'h00C

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CLEAR_STOP_BIT 0
`define CLEAR_TRACTION_BIT 1
`define NV_ROOF_BIT 0
`define NV_PIT_BIT 1
`define NV_STOP_BIT 2
`define NV_TRACTION_BIT 3
`define BRAKE_MS_RESET 10'h261
`define WIRED_RESET 2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ 125000000
`define HOLD_MIN_MS 3000
`define HOLD_MAX_MS 6000
`define STANDSTILL_MS 69
`define DECEL_WAIT_MS 100

`endif

// ==== reset_press_qualifier.v ====
// Purpose: Qualify a reset button press by its hold time
// Assumes: btn is already synchronised, ms_tick is a 1 ms enable
// Notes: valid pulses one cycle on release of a good press
`timescale 1ns/10ps
`default_nettype none
module reset_press_qualifier #(
  parameter integer MIN_MS = 3000,
  parameter integer MAX_MS = 6000
) (
  input wire pclk,
  input wire presetn,
  input wire ms_tick,
  input wire btn,
  output reg valid
);

  reg [12:0] held_ms;
  reg btn_q;

  // ----------------------------------------------------------------
  // Hold timer, saturating past the upper limit
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_ms <= 13'h0000;
      btn_q <= 1'b0;
      valid <= 1'b0;
    end else begin
      btn_q <= btn;
      // Release of a press inside the window only
      valid <= btn_q && !btn && (held_ms >= MIN_MS[12:0]) &&
        (held_ms <= MAX_MS[12:0]);
      if (!btn) begin
        held_ms <= 13'h0000;
      end else if (ms_tick && (held_ms <= MAX_MS[12:0])) begin
        held_ms <= held_ms + 13'h0001;
      end
    end
  end

endmodule
`default_nettype wire

// ==== lift_safety_props.sv ====
// Purpose: Concurrent checks on the shaft access safety logic ports
// Assumes: One clock domain, presetn asynchronous and active low
// Notes: Attached to every instance of the design by bind
`timescale 1ns/10ps
`default_nettype none
module lift_safety_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic roof_door_closed,
  input wire logic roof_insp_on,
  input wire logic pit_insp_on,
  input wire logic pit_guard_active,
  input wire logic safety_circuit_closed,
  input wire logic roof_end_switch,
  input wire logic pit_end_switch,
  input wire logic nv_rd_valid,
  input wire logic safety_circuit_relay,
  input wire logic safety_brake_relay,
  input wire logic normal_op_allowed,
  input wire logic pit_insp_unlock
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic loaded;
  // Notes when the stored image has been handed over
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) loaded <= 1'b0;
    else if (nv_rd_valid) loaded <= 1'b1;
  end
  AST_LOAD_FIRST: assert property (!loaded |-> !safety_circuit_relay && !safety_brake_relay
    && !normal_op_allowed) else $error("relay closed before stored state loaded");
  AST_DOOR_BLOCKS: assert property ((!roof_door_closed)[*8] |-> !normal_op_allowed)
    else $error("normal operation with roof door open");
  AST_INSP_BLOCKS: assert property ((roof_insp_on || pit_insp_on)[*8] |-> !normal_op_allowed)
    else $error("normal operation during inspection");
  AST_END_OPENS: assert property ((roof_end_switch || pit_end_switch)[*8] |->
    !safety_circuit_relay) else $error("circuit relay closed at end switch");
  AST_BRAKE_HOLDS: assert property (!safety_brake_relay && !$past(safety_brake_relay) |->
    !safety_circuit_relay) else $error("circuit relay closed after brake trip");
  AST_UNLOCK_PULSE: assert property (pit_insp_unlock |=> !pit_insp_unlock)
    else $error("pit unlock longer than one cycle");
  AST_INSP_REFUSE: assert property (pit_insp_on[*8] |-> !pit_insp_unlock)
    else $error("pit reset accepted with inspection on");
  AST_GUARD_REFUSE: assert property (pit_guard_active[*8] |-> !pit_insp_unlock)
    else $error("pit reset accepted with safeguard active");
  AST_OPEN_REFUSE: assert property ((!safety_circuit_closed)[*8] |-> !pit_insp_unlock)
    else $error("pit reset accepted with circuit open");
  AST_UNMAPPED: assert property (psel && !penable && paddr > 12'h00C |=> pslverr && pready)
    else $error("unmapped access not flagged");
  AST_MAPPED: assert property (psel && !penable && paddr[1:0] == 2'h0 && paddr <= 12'h00C
    |=> !pslverr) else $error("mapped access flagged");
  cover property ($rose(pit_insp_unlock));
  cover property ($fell(safety_brake_relay));
  cover property (psel && penable && pslverr);
endmodule
bind lift_shaft_access_safety_logic lift_safety_props u_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .roof_door_closed(roof_door_closed), .roof_insp_on(roof_insp_on),
  .pit_insp_on(pit_insp_on), .pit_guard_active(pit_guard_active),
  .safety_circuit_closed(safety_circuit_closed), .roof_end_switch(roof_end_switch),
  .pit_end_switch(pit_end_switch), .nv_rd_valid(nv_rd_valid),
  .safety_circuit_relay(safety_circuit_relay), .safety_brake_relay(safety_brake_relay),
  .normal_op_allowed(normal_op_allowed), .pit_insp_unlock(pit_insp_unlock));
`default_nettype wire

// ==== nv_store_model.sv ====
// Purpose: Behavioural non-volatile store beside the safety logic
// Assumes: Image survives presetn, answers once per boot
// Notes: Data lines carry the inverted image outside the answer
`timescale 1ns/10ps
`default_nettype none
module nv_store_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic nv_wr_en,
  input wire logic [3:0] nv_wr_data,
  output var logic nv_rd_valid,
  output var logic [3:0] nv_rd_data
);
  logic [3:0] mem = 4'h0;
  logic done;
  int wait_cnt;
  // Keeps latch image across resets, hands it over after boot
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 0;
      done <= 1'b0;
      nv_rd_valid <= 1'b0;
      nv_rd_data <= ~mem;
    end else begin
      nv_rd_valid <= 1'b0;
      nv_rd_data <= ~mem;
      if (nv_wr_en) mem <= nv_wr_data;
      if (!done) wait_cnt <= wait_cnt + 1;
      if (!done && wait_cnt == 8) begin
        nv_rd_valid <= 1'b1;
        nv_rd_data <= mem;
        done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the shaft access safety logic
// Assumes: One ms is 4 cycles, good press window 3 to 6 ms
// Notes: Pins change at a rising edge, outputs read at a later one
`timescale 1ns/10ps
`default_nettype none
`include "lift_access_regs.vh"
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, s, rd;
  logic roof_door_closed, pit_door_closed, roof_reset_btn, pit_reset_btn;
  logic roof_insp_on, pit_insp_on, roof_guard_active, pit_guard_active;
  logic safety_circuit_closed, roof_end_switch, pit_end_switch, car_moving;
  logic car_decelerating, boot_locked_cfg, site_key, nv_rd_valid, nv_wr_en;
  logic [3:0] nv_rd_data, nv_wr_data;
  logic safety_circuit_relay, safety_brake_relay, normal_op_allowed;
  logic inspection_allowed, pit_insp_unlock;
  logic [1:0] sel;
  int n_mismatch = 0, n_compared = 0, cyc = 0, n_unlock = 0;
  typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_t;
  row_t rows [10] = '{'{1'b0, `REG_BRAKE_MS_OFS, 32'h0, 32'h261, 1'b0},
    '{1'b0, `REG_WIRED_OFS, 32'h0, 32'h3, 1'b0}, '{1'b0, `REG_CLEAR_OFS, 32'h0, 32'h0, 1'b0},
    '{1'b1, `REG_BRAKE_MS_OFS, 32'hFFFFF00A, 32'h0, 1'b0},
    '{1'b0, `REG_BRAKE_MS_OFS, 32'h0, 32'h00A, 1'b0},
    '{1'b1, `REG_WIRED_OFS, 32'hFFFFFFFC, 32'h0, 1'b0},
    '{1'b0, `REG_WIRED_OFS, 32'h0, 32'h0, 1'b0}, '{1'b1, `REG_WIRED_OFS, 32'h3, 32'h0, 1'b0},
    '{1'b0, 12'h010, 32'h0, 32'h0, 1'b1}, '{1'b1, 12'h010, 32'h5, 32'h0, 1'b1}};
  lift_shaft_access_safety_logic #(.CYCLES_PER_MS(4), .HOLD_MIN_MS(3), .HOLD_MAX_MS(6)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .roof_door_closed(roof_door_closed), .pit_door_closed(pit_door_closed),
    .roof_reset_btn(roof_reset_btn), .pit_reset_btn(pit_reset_btn),
    .roof_insp_on(roof_insp_on), .pit_insp_on(pit_insp_on),
    .roof_guard_active(roof_guard_active), .pit_guard_active(pit_guard_active),
    .safety_circuit_closed(safety_circuit_closed), .roof_end_switch(roof_end_switch),
    .pit_end_switch(pit_end_switch), .car_moving(car_moving),
    .car_decelerating(car_decelerating), .boot_locked_cfg(boot_locked_cfg),
    .site_key(site_key), .nv_rd_valid(nv_rd_valid), .nv_rd_data(nv_rd_data),
    .nv_wr_en(nv_wr_en), .nv_wr_data(nv_wr_data), .safety_circuit_relay(safety_circuit_relay),
    .safety_brake_relay(safety_brake_relay), .normal_op_allowed(normal_op_allowed),
    .inspection_allowed(inspection_allowed), .pit_insp_unlock(pit_insp_unlock));
  nv_store_model partner (.pclk(pclk), .presetn(presetn), .nv_wr_en(nv_wr_en),
    .nv_wr_data(nv_wr_data), .nv_rd_valid(nv_rd_valid), .nv_rd_data(nv_rd_data));
  // Clock, cycle ceiling and unlock pulse count
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (pit_insp_unlock === 1'b1) n_unlock <= n_unlock + 1;
    if (cyc == 30000) begin
      n_mismatch = n_mismatch + 1;
      print_verdict;
    end
  end
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // APB transfer, held until pready is seen high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task rs;
    apb(1'b0, `REG_STATUS_OFS, 32'h0, s, err);
  endtask
  task clr(input logic [31:0] v);
    site_key <= 1'b1;
    wt(10);
    apb(1'b1, `REG_CLEAR_OFS, v, rd, err);
    site_key <= 1'b0;
    wt(10);
    rs;
  endtask
  task do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    wt(5);
    check(safety_circuit_relay, 0);
    presetn <= 1'b1;
    wt(20);
  endtask
  task press(input logic p, input int ms);
    if (p) pit_reset_btn <= 1'b1;
    else roof_reset_btn <= 1'b1;
    wt(ms * 4);
    {pit_reset_btn, roof_reset_btn} <= 2'b00;
    wt(12);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {roof_reset_btn, pit_reset_btn, roof_insp_on, pit_insp_on, roof_guard_active} = '0;
    {pit_guard_active, roof_end_switch, pit_end_switch, car_moving, car_decelerating} = '0;
    {boot_locked_cfg, site_key} = '0;
    {roof_door_closed, pit_door_closed, safety_circuit_closed} = '1;
    do_reset;
    check(safety_brake_relay, 1);
    check(normal_op_allowed, 1);
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d, rd, err);
      if (!rows[i].wr) check(rd, rows[i].q);
      check(err, rows[i].e);
    end
    $display("test reset and registers done");
    {roof_door_closed, pit_door_closed} <= 2'b00;
    wt(10);
    check(normal_op_allowed, 0);
    check(safety_circuit_relay, 0);
    {roof_door_closed, pit_door_closed} <= 2'b11;
    wt(10);
    rs;
    check(s[1:0], 2'h3);
    check(partner.mem[1:0], 2'h3);
    check(inspection_allowed, 1);
    check(normal_op_allowed, 0);
    for (int p = 0; p < 2; p++) for (int k = 0; k < 5; k++) begin
      sel = p ? 2'b10 : 2'b01;
      {pit_insp_on, roof_insp_on} <= (k == 2) ? sel : 2'b00;
      {pit_guard_active, roof_guard_active} <= (k == 3) ? sel : 2'b00;
      safety_circuit_closed <= (k != 4);
      press(p[0], (k == 0) ? 1 : ((k == 1) ? 8 : 4));
      rs;
      check(s[1:0], 2'h3);
    end
    {pit_insp_on, roof_insp_on, pit_guard_active, roof_guard_active} <= 4'h0;
    safety_circuit_closed <= 1'b1;
    wt(10);
    press(0, 4);
    rs;
    check(s[1:0], 2'h2);
    check(normal_op_allowed, 0);
    check(n_unlock, 0);
    press(1, 4);
    rs;
    check(s[1:0], 2'h0);
    check(n_unlock, 1);
    check(normal_op_allowed, 1);
    $display("test access reset done");
    {pit_end_switch, car_moving, car_decelerating} <= 3'b111;
    wt(10);
    check(safety_circuit_relay, 0);
    wt(420);
    check(safety_brake_relay, 1);
    {pit_end_switch, car_decelerating, roof_end_switch} <= 3'b001;
    wt(420);
    check(safety_brake_relay, 0);
    {roof_end_switch, car_moving} <= 2'b00;
    wt(20);
    check(safety_circuit_relay, 0);
    apb(1'b1, `REG_CLEAR_OFS, 32'h1, rd, err);
    do_reset;
    rs;
    check(s[2], 1);
    check(safety_brake_relay, 0);
    clr(32'h1);
    check(s[2], 0);
    check(safety_circuit_relay, 1);
    $display("test stopping done");
    safety_circuit_closed <= 1'b0;
    wt(20);
    car_moving <= 1'b1;
    wt(230);
    check(safety_brake_relay, 1);
    wt(80);
    check(safety_brake_relay, 0);
    check(safety_circuit_relay, 0);
    {car_moving, safety_circuit_closed} <= 2'b01;
    wt(20);
    rs;
    check(s[3], 1);
    clr(32'h2);
    check(s[3], 0);
    check(safety_brake_relay, 1);
    car_moving <= 1'b1;
    wt(10);
    safety_circuit_closed <= 1'b0;
    wt(2400);
    check(safety_brake_relay, 1);
    wt(80);
    check(safety_brake_relay, 0);
    $display("test traction done");
    boot_locked_cfg <= 1'b1;
    do_reset;
    rs;
    check(s[1:0], 2'h3);
    check(normal_op_allowed, 0);
    $display("test boot lock done");
    print_verdict;
  end
endmodule
`default_nettype wire
